// ==== rtl/cm_frame_pkg.sv ====
// Purpose: Shared constants and carrier types for the control message framer.
// Assumes: Byte streams on one clock; Wishbone classic register port.
// Notes:   Multi-byte fields travel most significant byte first.
package cm_frame_pkg;
   // Framing header field values
   localparam logic [15:0] PROTO_ID_V1      = 16'h0001;
   localparam logic [15:0] TAG_UNUSED       = 16'h0000;
   localparam logic [15:0] TRANSPORT_PORT   = 16'h1ffe;
   localparam logic [7:0]  SEL_DEFAULT      = 8'h00;
   localparam logic [3:0]  HDR_BYTES        = 4'h7;
   localparam logic [3:0]  AVP_HDR_BYTES    = 4'h8;
   localparam logic [15:0] AVP_ORG_DEFAULT  = 16'h0000; // Arbitrary
   localparam logic [15:0] AVP_TYPE_DEFAULT = 16'h0000;
   localparam logic [1:0]  AVP_VER_DEFAULT  = 2'h1;
   // Register byte offsets
   localparam logic [7:0] REG_CTRL    = 8'h00;
   localparam logic [7:0] REG_STATUS  = 8'h04;
   localparam logic [7:0] REG_TXTAG   = 8'h08;
   localparam logic [7:0] REG_TXLEN   = 8'h0c;
   localparam logic [7:0] REG_AVPID   = 8'h10;
   localparam logic [7:0] REG_RXHDR   = 8'h14;
   localparam logic [7:0] REG_RXCNT   = 8'h18;
   localparam logic [7:0] REG_PORT    = 8'h1c;
   // Control register fields
   localparam int CTRL_TXGO    = 0;
   localparam int CTRL_AVPMODE = 1;
   localparam int CTRL_HIDDEN  = 2;
   localparam int CTRL_MAND    = 3;
   localparam int CTRL_SEL_LSB = 8;
   localparam int CTRL_VER_LSB = 16;
   localparam logic [31:0] CTRL_RESET = 32'h0001_0000;
   // Status register fields
   localparam int ST_TXBUSY  = 0;
   localparam int ST_RXBAD   = 1;
   localparam int ST_RXTAGOK = 2;

   // Byte stream beat
   typedef struct packed {
      logic [7:0] data;
      logic       last;
   } beat_t;

   // Framer states
   typedef enum logic [1:0] {
      TX_IDLE = 2'b00,
      TX_HDR  = 2'b01,
      TX_BODY = 2'b10
   } tx_state_t;
   typedef enum logic [1:0] {
      RX_HDR  = 2'b00,
      RX_BODY = 2'b01,
      RX_DROP = 2'b10
   } rx_state_t;
endpackage

// ==== rtl/cm_framer.sv ====
// Purpose: Builds and parses transport framing around control messages.
// Assumes: Message bytes arrive whole; transport stack lies outside.
// Notes:   Plain header for TCP or UDP, or tunnelling attribute, chosen by a control bit on transmit; receive parses the plain header only.

// Function
// - Header opens with two-byte tag, zero ignored
// - Protocol identifier two bytes, value one
// - Length counts selector plus message bytes
// - One-byte selector ends header, default zero
// - One header then whole messages, all extracted
// - Zero header tag ignored by receiver
// - Transport port number is 8190
// - UDP uses same port and header
// - Ports scoped by header selector
// - Hidden flag set when contents encrypted
// - Four reserved flag bits sent zero
// - Ten-bit length covers whole attribute
// - Organization code and type configurable
// - Six reserved payload bits sent zero
// - Two-bit version then eight-bit selector
// - Attribute holds no tag, only messages

`timescale 1ns/1ps
module cm_framer (
   // Clock and reset
   input  wire  logic                 ref_clk,
   input  wire  logic                 rst_n,

   // Wishbone classic slave
   input  wire  logic                 wb_cyc_i,
   input  wire  logic                 wb_stb_i,
   input  wire  logic                 wb_we_i,
   input  wire  logic [7:0]           wb_adr_i,
   input  wire  logic [3:0]           wb_sel_i,
   input  wire  logic [31:0]          wb_dat_i,
   output logic       [31:0]          wb_dat_o,
   output logic                       wb_ack_o,

   // Outgoing message bytes from the control logic
   input  wire  cm_frame_pkg::beat_t  txMsg,
   input  wire  logic                 txMsgValid,
   output logic                       txMsgReady,

   // Framed bytes out to the transport
   output cm_frame_pkg::beat_t        txOut,
   output logic                       txOutValid,
   input  wire  logic                 txOutReady,

   // Framed bytes in from the transport
   input  wire  cm_frame_pkg::beat_t  rxIn,
   input  wire  logic                 rxInValid,
   output logic                       rxInReady,

   // Extracted message bytes with their unit scope
   output cm_frame_pkg::beat_t        rxMsg,
   output logic [7:0]                 rxMsgSel,
   output logic                       rxMsgValid,
   input  wire  logic                 rxMsgReady
);

   // All state in one record
   typedef struct packed {
      // Registers
      logic [31:0]             ctrl;       // Control word
      logic [15:0]             txTag;      // Header tag to send
      logic [15:0]             txLen;      // Message bytes to send
      logic [31:0]             avpId;      // Organization code and type

      // Transmit
      cm_frame_pkg::tx_state_t txSt;       // Transmit state
      logic [3:0]              txIdx;      // Header byte index
      cm_frame_pkg::beat_t     [1:0] buf_; // Two-entry output buffer
      logic                    wp;         // Buffer write slot
      logic                    rp;         // Buffer read slot
      logic [1:0]              cnt;        // Buffer fill

      // Receive
      cm_frame_pkg::rx_state_t rxSt;       // Receive state
      logic [2:0]              rxIdx;      // Header byte index
      logic [15:0]             rxTag;      // Received header tag
      logic [15:0]             rxProto;    // Received identifier
      logic [15:0]             rxRemain;   // Bytes left in payload
      logic [7:0]              rxSel;      // Received selector
      logic                    rxBad;      // Sticky bad frame
      logic                    rxTagOk;    // Header tag meaningful
      logic [15:0]             rxFrames;   // Frames with payload complete
      cm_frame_pkg::beat_t     rxData;     // Output data register
      logic [7:0]              rxDSel;     // Scope of output data
      logic                    rxValid;    // Output data valid

      // Bus
      logic                    ack;        // Bus acknowledge
      logic [31:0]             rdat;       // Bus read data
   } state_t;

   state_t s_r;   // Registered state
   state_t s_nxt; // Next state

   // Merge bytes of a write by select lanes
   function automatic logic [31:0] laneMerge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  sel);
      logic [31:0] m;
      // Unselected lanes stay
      m = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            m[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return m;
   endfunction

   // Header byte at index, high byte first
   function automatic logic [7:0] hdrByte(input state_t s, input logic [3:0] i);
      logic [15:0] len;
      logic [7:0]  sel;
      logic [9:0]  alen;
      sel  = s.ctrl[cm_frame_pkg::CTRL_SEL_LSB +: 8];
      len  = s.txLen + 16'h0001;
      // whole attribute length
      // Header plus payload head
      alen = 10'(s.txLen + {12'h000, cm_frame_pkg::AVP_HDR_BYTES});

      // Beyond header: zero
      hdrByte = 8'h00;
      if (s.ctrl[cm_frame_pkg::CTRL_AVPMODE]) begin
         case (i)
            4'h0:    hdrByte = {s.ctrl[cm_frame_pkg::CTRL_MAND],
                                s.ctrl[cm_frame_pkg::CTRL_HIDDEN], 4'h0, alen[9:8]};
            4'h1:    hdrByte = alen[7:0];
            4'h2:    hdrByte = s.avpId[31:24];
            4'h3:    hdrByte = s.avpId[23:16];
            4'h4:    hdrByte = s.avpId[15:8];
            4'h5:    hdrByte = s.avpId[7:0];
            4'h6:    hdrByte = {6'h00, s.ctrl[cm_frame_pkg::CTRL_VER_LSB +: 2]};
            4'h7:    hdrByte = sel;
            default: hdrByte = 8'h00;
         endcase
      end else begin
         case (i)
            4'h0:    hdrByte = s.txTag[15:8];
            4'h1:    hdrByte = s.txTag[7:0];
            4'h2:    hdrByte = cm_frame_pkg::PROTO_ID_V1[15:8];
            4'h3:    hdrByte = cm_frame_pkg::PROTO_ID_V1[7:0];
            4'h4:    hdrByte = len[15:8];
            4'h5:    hdrByte = len[7:0];
            4'h6:    hdrByte = sel;
            default: hdrByte = 8'h00;
         endcase
      end
   endfunction

   // Helpers
   logic bufIn;       // Byte pushed into buffer this cycle
   logic bufOut;      // Byte popped from buffer this cycle
   logic hdrLastIdx;  // Last header byte index
   logic rxTake;      // Input byte accepted
   logic wbReq;       // New bus request

   // Next-state logic
   always_comb begin
      state_t n;
      logic [3:0] hdrLen;
      cm_frame_pkg::beat_t b;
      // Hold by default
      n      = s_r;
      b      = '0;
      bufIn  = 1'b0;
      hdrLen = s_r.ctrl[cm_frame_pkg::CTRL_AVPMODE] ? cm_frame_pkg::AVP_HDR_BYTES
                                                    : cm_frame_pkg::HDR_BYTES;
      hdrLastIdx = (s_r.txIdx == hdrLen - 4'h1);
      txMsgReady = (s_r.txSt == cm_frame_pkg::TX_BODY) && (s_r.cnt != 2'h2);
      bufOut     = (s_r.cnt != 2'h0) && txOutReady;

      // Bus slave: one wait state, ack drops after one cycle
      wbReq = wb_cyc_i && wb_stb_i && !s_r.ack;
      n.ack = wbReq;
      if (wbReq) begin
         // Unmapped read zero
         n.rdat = 32'h0;
         case (wb_adr_i)
            cm_frame_pkg::REG_CTRL:   n.rdat = s_r.ctrl;
            cm_frame_pkg::REG_STATUS: n.rdat = {29'h0, s_r.rxTagOk, s_r.rxBad,
                                                (s_r.txSt != cm_frame_pkg::TX_IDLE)};
            cm_frame_pkg::REG_TXTAG:  n.rdat = {16'h0, s_r.txTag};
            cm_frame_pkg::REG_TXLEN:  n.rdat = {16'h0, s_r.txLen};
            cm_frame_pkg::REG_AVPID:  n.rdat = s_r.avpId;
            cm_frame_pkg::REG_RXHDR:  n.rdat = {s_r.rxTag, s_r.rxProto};
            cm_frame_pkg::REG_RXCNT:  n.rdat = {8'h0, s_r.rxSel, s_r.rxFrames};
            // one port for TCP and UDP
            cm_frame_pkg::REG_PORT:   n.rdat = {16'h0, cm_frame_pkg::TRANSPORT_PORT};
            default:                  n.rdat = 32'h0;
         endcase
         // Write on take
         if (wb_we_i) begin
            case (wb_adr_i)
               cm_frame_pkg::REG_CTRL:  n.ctrl  = laneMerge(s_r.ctrl, wb_dat_i, wb_sel_i);
               cm_frame_pkg::REG_TXTAG: n.txTag = 16'(laneMerge({16'h0, s_r.txTag},
                                                                wb_dat_i, wb_sel_i));
               cm_frame_pkg::REG_TXLEN: n.txLen = 16'(laneMerge({16'h0, s_r.txLen},
                                                                wb_dat_i, wb_sel_i));
               cm_frame_pkg::REG_AVPID: n.avpId = laneMerge(s_r.avpId, wb_dat_i, wb_sel_i);
               // Writing one clears the sticky error
               cm_frame_pkg::REG_STATUS: begin
                  if (wb_sel_i[0] && wb_dat_i[cm_frame_pkg::ST_RXBAD]) begin
                     n.rxBad = 1'b0;
                  end
               end
               default: ;
            endcase
         end
      end

      // Transmit framer; go bit self-clears when the frame starts
      case (s_r.txSt)
         cm_frame_pkg::TX_IDLE: begin
            // Wait for go
            if (s_r.ctrl[cm_frame_pkg::CTRL_TXGO]) begin
               n.ctrl[cm_frame_pkg::CTRL_TXGO] = 1'b0;
               n.txIdx = 4'h0;
               n.txSt  = cm_frame_pkg::TX_HDR;
            end
         end

         cm_frame_pkg::TX_HDR: begin
            if (s_r.cnt != 2'h2) begin
               bufIn   = 1'b1;
               b.data  = hdrByte(s_r, s_r.txIdx);
               // Closes empty frames
               b.last  = hdrLastIdx && (s_r.txLen == 16'h0);
               n.txIdx = s_r.txIdx + 4'h1;
               if (hdrLastIdx) begin
                  n.txSt = (s_r.txLen == 16'h0) ? cm_frame_pkg::TX_IDLE
                                                : cm_frame_pkg::TX_BODY;
               end
            end
         end

         cm_frame_pkg::TX_BODY: begin
            // Bytes pass on; frame ends after the programmed count
            if (txMsgValid && txMsgReady) begin
               bufIn   = 1'b1;
               b.data  = txMsg.data;
               b.last  = (s_r.txLen == 16'h1);
               n.txLen = s_r.txLen - 16'h1;
               if (s_r.txLen == 16'h1) begin
                  n.txSt = cm_frame_pkg::TX_IDLE;
               end
            end
         end
         default: n.txSt = cm_frame_pkg::TX_IDLE;
      endcase

      // Two-entry buffer keeps bytes through a stall
      if (bufIn) begin
         n.buf_[s_r.wp] = b;
         n.wp = ~s_r.wp;
      end
      // Pop on take
      if (bufOut) begin
         n.rp = ~s_r.rp;
      end
      // Fill count
      n.cnt = 2'(s_r.cnt + {1'b0, bufIn} - {1'b0, bufOut});

      // Receive parser
      rxInReady = !s_r.rxValid || rxMsgReady;
      rxTake    = rxInValid && rxInReady;
      if (s_r.rxValid && rxMsgReady) begin
         n.rxValid = 1'b0;
      end
      if (rxTake) begin
         // Taken bytes only
         case (s_r.rxSt)
            cm_frame_pkg::RX_HDR: begin
               // High byte first
               n.rxIdx = s_r.rxIdx + 3'h1;
               case (s_r.rxIdx)
                  3'h0:    n.rxTag[15:8]    = rxIn.data;
                  3'h1:    n.rxTag[7:0]     = rxIn.data;
                  3'h2:    n.rxProto[15:8]  = rxIn.data;
                  3'h3:    n.rxProto[7:0]   = rxIn.data;
                  3'h4:    n.rxRemain[15:8] = rxIn.data;
                  3'h5:    n.rxRemain[7:0]  = rxIn.data;
                  default: n.rxSel          = rxIn.data;
               endcase
               if (s_r.rxIdx == 3'h6) begin
                  n.rxIdx = 3'h0;
                  n.rxTagOk = (s_r.rxTag != cm_frame_pkg::TAG_UNUSED);
                  // reject foreign, empty or cut frames
                  if (s_r.rxProto != cm_frame_pkg::PROTO_ID_V1 ||
                      s_r.rxRemain < 16'h2 || rxIn.last) begin
                     n.rxBad = 1'b1;
                     n.rxSt  = rxIn.last ? cm_frame_pkg::RX_HDR : cm_frame_pkg::RX_DROP;
                  end else begin
                     n.rxRemain = s_r.rxRemain - 16'h1;
                     n.rxSt     = cm_frame_pkg::RX_BODY;
                  end
               end else if (rxIn.last) begin
                  n.rxBad = 1'b1;
                  n.rxIdx = 3'h0;
               end
            end

            cm_frame_pkg::RX_BODY: begin
               n.rxValid    = 1'b1;
               n.rxData     = '{data: rxIn.data, last: (s_r.rxRemain == 16'h1)};
               n.rxDSel     = s_r.rxSel;
               n.rxRemain   = s_r.rxRemain - 16'h1;
               // Payload end
               if (s_r.rxRemain == 16'h1) begin
                  n.rxFrames = s_r.rxFrames + 16'h1;
                  n.rxSt     = rxIn.last ? cm_frame_pkg::RX_HDR : cm_frame_pkg::RX_DROP;
                  if (!rxIn.last) begin
                     n.rxBad = 1'b1;
                  end
               end else if (rxIn.last) begin
                  n.rxBad = 1'b1;
                  n.rxData.last = 1'b1;
                  n.rxSt  = cm_frame_pkg::RX_HDR;
               end
            end

            cm_frame_pkg::RX_DROP: begin
               // Discard to end of transport payload
               if (rxIn.last) begin
                  n.rxSt = cm_frame_pkg::RX_HDR;
               end
            end
            default: n.rxSt = cm_frame_pkg::RX_HDR;
         endcase
      end
      s_nxt = n;
   end

   // State register
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r       <= '0;
         // Package defaults; control word nonzero
         s_r.ctrl  <= cm_frame_pkg::CTRL_RESET;
         s_r.avpId <= {cm_frame_pkg::AVP_ORG_DEFAULT, cm_frame_pkg::AVP_TYPE_DEFAULT};
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs
   assign wb_ack_o   = s_r.ack;
   assign wb_dat_o   = s_r.rdat;

   // Stream outputs
   assign txOut      = s_r.buf_[s_r.rp];
   assign txOutValid = (s_r.cnt != 2'h0);

   assign rxMsg      = s_r.rxData;
   assign rxMsgSel   = s_r.rxDSel;
   assign rxMsgValid = s_r.rxValid;
endmodule

// ==== tb/cm_framer_asserts.sv ====
// Purpose: Concurrent checks on the control message framer ports.
// Assumes: One clock domain; control register mirrored from bus writes.
// Notes:   Frame byte index counts accepted output beats.
`timescale 1ns/1ps
module cm_framer_asserts (
   // Clock and reset
   input wire logic                ref_clk,
   input wire logic                rst_n,
   // Register port
   input wire logic                wb_cyc_i,
   input wire logic                wb_stb_i,
   input wire logic                wb_we_i,
   input wire logic [7:0]          wb_adr_i,
   input wire logic [3:0]          wb_sel_i,
   input wire logic [31:0]         wb_dat_i,
   input wire logic [31:0]         wb_dat_o,
   input wire logic                wb_ack_o,
   // Stream ports
   input wire cm_frame_pkg::beat_t txOut,
   input wire logic                txOutValid,
   input wire logic                txOutReady,
   input wire cm_frame_pkg::beat_t rxMsg,
   input wire logic [7:0]          rxMsgSel,
   input wire logic                rxMsgValid,
   input wire logic                rxMsgReady
);
   logic [31:0] ctrlR; // Mirror of control register
   logic [7:0]  idxR;  // Byte index within outgoing frame
   logic        hs;    // Output beat accepted
   logic        avp;   // Attribute framing selected
   assign hs  = txOutValid && txOutReady;
   assign avp = ctrlR[1];
   // Mirror writes at the edge that ends the ack cycle, one edge after the block applies them
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrlR <= cm_frame_pkg::CTRL_RESET;
         idxR  <= 8'h00;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (wb_ack_o && wb_we_i && wb_adr_i == cm_frame_pkg::REG_CTRL && wb_sel_i[i]) begin
               ctrlR[8*i+:8] <= wb_dat_i[8*i+:8];
            end
         end
         // Index restarts after the final byte so the next frame lines up
         if (hs) begin
            idxR <= txOut.last ? 8'h00 : idxR + 8'h01;
         end
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing after request");
   chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   chk_port_read: assert property (
      wb_ack_o && !wb_we_i && wb_adr_i == cm_frame_pkg::REG_PORT |-> wb_dat_o == 32'h0000_1ffe)
      else $error("port register wrong");
   chk_tx_hold: assert property (txOutValid && !txOutReady |=> txOutValid && $stable(txOut))
      else $error("output beat changed while stalled");
   chk_rx_hold: assert property (
      rxMsgValid && !rxMsgReady |=> rxMsgValid && $stable(rxMsg) && $stable(rxMsgSel))
      else $error("message beat changed while stalled");
   chk_proto_bytes: assert property (
      hs && !avp && idxR inside {8'h02, 8'h03} |-> txOut.data == {7'h00, idxR[0]})
      else $error("protocol identifier wrong");
   chk_sel_byte: assert property (hs && !avp && idxR == 8'h06 |-> txOut.data == ctrlR[15:8])
      else $error("selector byte wrong");
   chk_avp_flags: assert property (
      hs && avp && idxR == 8'h00 |-> txOut.data[7:2] == {ctrlR[3], ctrlR[2], 4'h0})
      else $error("attribute flags wrong");
   chk_avp_version: assert property (
      hs && avp && idxR == 8'h06 |-> txOut.data == {6'h00, ctrlR[17:16]})
      else $error("attribute version byte wrong");
endmodule

// ==== tb/cm_framer_test.sv ====
// Purpose: Self-checking bench for the control message framer.
// Assumes: Registers over classic Wishbone; peer model on the transport side.
// Notes:   Expected frames are built by hand from the field layout.
`timescale 1ns/1ps
module cm_framer_test;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, txMsgValid = 1'b0;
   logic rxMsgReady = 1'b0, slow = 1'b0;
   logic [7:0] wb_adr_i = 8'h00, sinkCnt = 8'h00, rxMsgSel;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
   logic wb_ack_o, txMsgReady, txOutValid, txOutReady, rxInValid, rxInReady, rxMsgValid;
   cm_frame_pkg::beat_t txMsg = '0, txOut, rxIn, rxMsg;
   logic [7:0] msgQ[$], expQ[$];   // Message bytes to send, expected frame
   logic [16:0] capQ[$], expR[$];  // Captured and expected {sel, data, last}
   int mismatches = 0, cmp_count = 0;
   always #20 ref_clk = ~ref_clk;
   cm_framer uut (.ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .txMsg(txMsg), .txMsgValid(txMsgValid),
      .txMsgReady(txMsgReady), .txOut(txOut), .txOutValid(txOutValid), .txOutReady(txOutReady),
      .rxIn(rxIn), .rxInValid(rxInValid), .rxInReady(rxInReady), .rxMsg(rxMsg),
      .rxMsgSel(rxMsgSel), .rxMsgValid(rxMsgValid), .rxMsgReady(rxMsgReady));
   transport_peer peer (.ref_clk(ref_clk), .rst_n(rst_n), .slow(slow), .txOut(txOut),
      .txOutValid(txOutValid), .txOutReady(txOutReady), .rxIn(rxIn), .rxInValid(rxInValid),
      .rxInReady(rxInReady));
   // Message source holds each byte until taken; idle data toggles
   always @(posedge ref_clk) begin
      if (!txMsgValid || txMsgReady) begin
         txMsgValid <= (msgQ.size() > 0);
         txMsg.data <= (msgQ.size() > 0) ? msgQ.pop_front() : ~txMsg.data;
      end
   end
   // Message sink stalls in a fixed pattern
   always @(posedge ref_clk) begin
      sinkCnt    <= sinkCnt + 8'h01;
      rxMsgReady <= sinkCnt[0] | sinkCnt[2];
      if (rxMsgValid === 1'b1 && rxMsgReady) capQ.push_back({rxMsgSel, rxMsg});
   end
   task end_sim;
      $display("counts: %0d compared, %0d mismatched", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task cmp_beat(input logic [16:0] got, input logic [16:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task cmp_word(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // One classic cycle; request held until ack is sampled
   task wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge ref_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= 4'hf;
      for (n = 0; n < 20; n++) begin
         @(posedge ref_clk);
         if (wb_ack_o === 1'b1) break;
      end
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
      if (n == 20) begin
         mismatches++;
         end_sim();
      end
   endtask
   // Bounded wait: 0 transmit count, 1 capture count, 2 receive drained
   task wait_until(input int want, input int m);
      int n;
      for (n = 0; n < 600; n++) begin
         if (m == 0 ? peer.txQ.size() >= want : m == 1 ? capQ.size() >= want :
             peer.rxQ.size() == 0 && rxInValid === 1'b0) break;
         @(posedge ref_clk);
      end
      if (n == 600) begin
         mismatches++;
         end_sim();
      end
   endtask
   task check_tx;
      wait_until(expQ.size(), 0);
      foreach (expQ[i]) cmp_beat({8'h00, peer.txQ[i]}, {8'h00, expQ[i], 1'(i == expQ.size() - 1)});
      peer.txQ.delete();
   endtask
   task check_rx;
      wait_until(expR.size(), 1);
      foreach (expR[i]) cmp_beat(capQ[i], expR[i]);
      capQ.delete();
   endtask
   task push_rx(input logic [7:0] b[]);
      foreach (b[i]) peer.rxQ.push_back({b[i], 1'(i == b.size() - 1)});
   endtask
   task test_regs;
      wb_xfer(1'b0, cm_frame_pkg::REG_CTRL, 32'h0);
      cmp_word(rd, 32'h0001_0000);
      wb_xfer(1'b0, cm_frame_pkg::REG_PORT, 32'h0);
      cmp_word(rd, 32'h0000_1ffe);
      wb_xfer(1'b1, 8'h20, 32'hffff_ffff);
      wb_xfer(1'b0, 8'h20, 32'h0);
      cmp_word(rd, 32'h0);
      $display("test_regs done");
   endtask
   task test_tx_plain;
      slow <= 1'b0;
      msgQ = '{8'ha0, 8'ha1, 8'ha2};
      wb_xfer(1'b1, cm_frame_pkg::REG_TXLEN, 32'h3);
      wb_xfer(1'b1, cm_frame_pkg::REG_TXTAG, 32'h1234);
      wb_xfer(1'b1, cm_frame_pkg::REG_CTRL, 32'h0001_5a01);
      expQ = '{8'h12, 8'h34, 8'h00, 8'h01, 8'h00, 8'h04, 8'h5a, 8'ha0, 8'ha1, 8'ha2};
      check_tx();
      $display("test_tx_plain done");
   endtask
   task test_tx_avp;
      slow <= 1'b1;
      msgQ = '{8'h5c, 8'h5d};
      wb_xfer(1'b1, cm_frame_pkg::REG_TXLEN, 32'h2);
      wb_xfer(1'b1, cm_frame_pkg::REG_AVPID, 32'habcd_0123);
      wb_xfer(1'b1, cm_frame_pkg::REG_CTRL, 32'h0001_070f);
      expQ = '{8'hc0, 8'h0a, 8'hab, 8'hcd, 8'h01, 8'h23, 8'h01, 8'h07, 8'h5c, 8'h5d};
      check_tx();
      $display("test_tx_avp done");
   endtask
   task test_rx;
      push_rx('{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h04, 8'h33, 8'hb0, 8'hb1, 8'hb2});
      expR = '{{8'h33, 8'hb0, 1'b0}, {8'h33, 8'hb1, 1'b0}, {8'h33, 8'hb2, 1'b1}};
      check_rx();
      wb_xfer(1'b0, cm_frame_pkg::REG_STATUS, 32'h0);
      cmp_word(rd & 32'h6, 32'h0);
      push_rx('{8'h00, 8'h07, 8'h00, 8'h02, 8'h00, 8'h02, 8'h00, 8'hc0});
      wait_until(0, 2);
      wb_xfer(1'b0, cm_frame_pkg::REG_STATUS, 32'h0);
      cmp_word(rd & 32'h2, 32'h2);
      cmp_word(32'(capQ.size()), 32'h0);
      wb_xfer(1'b1, cm_frame_pkg::REG_STATUS, 32'h2);
      wb_xfer(1'b0, cm_frame_pkg::REG_STATUS, 32'h0);
      cmp_word(rd & 32'h2, 32'h0);
      push_rx('{8'h00, 8'h07, 8'h00, 8'h01, 8'h00, 8'h02, 8'h44, 8'hd0});
      expR = '{{8'h44, 8'hd0, 1'b1}};
      check_rx();
      wb_xfer(1'b0, cm_frame_pkg::REG_STATUS, 32'h0);
      cmp_word(rd & 32'h4, 32'h4);
      wb_xfer(1'b0, cm_frame_pkg::REG_RXCNT, 32'h0);
      cmp_word(rd, 32'h0044_0002);
      $display("test_rx done");
   endtask
   initial begin
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      test_regs();
      test_tx_plain();
      test_tx_avp();
      test_rx();
      end_sim();
   end
endmodule
bind cm_framer cm_framer_asserts chk (.ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .txOut(txOut),
   .txOutValid(txOutValid), .txOutReady(txOutReady), .rxMsg(rxMsg), .rxMsgSel(rxMsgSel),
   .rxMsgValid(rxMsgValid), .rxMsgReady(rxMsgReady));

// ==== tb/transport_peer.sv ====
// Purpose: Transport side model that sinks framed bytes and sources payloads.
// Assumes: Bench pushes payload beats into rxQ and reads captures from txQ.
// Notes:   Idle receive data toggles so stale bytes never look valid.
`timescale 1ns/1ps
module transport_peer (
   // Clock and reset
   input  wire logic                ref_clk,
   input  wire logic                rst_n,
   // Stall mode
   input  wire logic                slow,
   // Framed bytes from the block
   input  wire cm_frame_pkg::beat_t txOut,
   input  wire logic                txOutValid,
   output logic                     txOutReady,
   // Framed bytes into the block
   output cm_frame_pkg::beat_t      rxIn,
   output logic                     rxInValid,
   input  wire logic                rxInReady
);
   cm_frame_pkg::beat_t txQ[$];  // Captured outgoing beats
   cm_frame_pkg::beat_t rxQ[$];  // Beats still to send
   logic [1:0]          stallCnt; // Stall pattern phase
   // Slow mode refuses one cycle in four to exercise the buffer
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         txOutReady <= 1'b0;
         rxInValid  <= 1'b0;
         rxIn       <= '0;
         stallCnt   <= 2'h0;
      end else begin
         stallCnt   <= stallCnt + 2'h1;
         txOutReady <= !slow || (stallCnt != 2'h0);
         if (txOutValid && txOutReady) begin
            txQ.push_back(txOut);
         end
         if (!rxInValid || rxInReady) begin
            if (rxQ.size() > 0) begin
               rxIn      <= rxQ.pop_front();
               rxInValid <= 1'b1;
            end else begin
               rxInValid <= 1'b0;
               rxIn      <= ~rxIn;
            end
         end
      end
   end
endmodule
